// *** bbse_defines.vh ***
// Opcode, flag position and cycle-count constants for the exec unit.
// Assumes nothing; included by both design files.
`ifndef BBSE_DEFINES_VH
`define BBSE_DEFINES_VH
`define BBSE_OP_NOP 4'h0
`define BBSE_OP_BR_VCLR 4'h1
`define BBSE_OP_BR_ISET 4'h2
`define BBSE_OP_BR_ICLR 4'h3
`define BBSE_OP_IOSET 4'h4
`define BBSE_OP_IOCLR 4'h5
`define BBSE_OP_SHL 4'h6
`define BBSE_OP_SHR 4'h7
`define BBSE_OP_RCL 4'h8
`define BBSE_OP_RCR 4'h9
`define BBSE_OP_SAR 4'ha
`define BBSE_OP_SWAP 4'hb
`define BBSE_OP_FSET 4'hc
`define BBSE_OP_FCLR 4'hd
`define BBSE_OP_BST 4'he
`define BBSE_FLAG_C 0
`define BBSE_FLAG_Z 1
`define BBSE_FLAG_N 2
`define BBSE_FLAG_V 3
`define BBSE_FLAG_S 4
`define BBSE_FLAG_H 5
`define BBSE_FLAG_T 6
`define BBSE_FLAG_I 7
`define BBSE_FLAG_C0 0
`define BBSE_STAT_RST 8'h00
`define BBSE_PC_RST 16'h0000
`define BBSE_CYC_BR_TAKEN 2'h2
`define BBSE_CYC_IO 2'h2
`endif

// *** bbse_shift.v ***
// Combinational shift, rotate and swap unit with status flag results.
// Assumes an 8-bit operand, old status byte, and opcode from the top.
`timescale 1ns/1ns
`include "bbse_defines.vh"
module bbse_shift (
    input wire [3:0] op_i,       // Operation code
    input wire [7:0] rd_i,       // Operand value
    input wire [7:0] stat_i,     // Current status byte
    output reg [7:0] res_o,      // Result value
    output reg [7:0] stat_o      // Updated status byte
);
    reg c;
    reg n;
    always @* begin
        res_o = rd_i;
        c = stat_i[`BBSE_FLAG_C0];
        case (op_i)
            `BBSE_OP_SHL: begin
                res_o = {rd_i[6:0], 1'b0};
                c = rd_i[7];
            end
            `BBSE_OP_SHR: begin
                res_o = {1'b0, rd_i[7:1]};
                c = rd_i[0];
            end
            `BBSE_OP_RCL: begin
                res_o = {rd_i[6:0], stat_i[`BBSE_FLAG_C0]};
                c = rd_i[7];
            end
            `BBSE_OP_RCR: begin
                res_o = {stat_i[`BBSE_FLAG_C0], rd_i[7:1]};
                c = rd_i[0];
            end
            `BBSE_OP_SAR: begin
                res_o = {rd_i[7], rd_i[7:1]};
                c = rd_i[0];
            end
            `BBSE_OP_SWAP: begin
                res_o = {rd_i[3:0], rd_i[7:4]};
            end
            default: begin
                res_o = rd_i;
            end
        endcase
        n = res_o[7];
        stat_o = stat_i;
        if (op_i != `BBSE_OP_SWAP) begin
            stat_o[`BBSE_FLAG_C0] = c;
            stat_o[`BBSE_FLAG_Z] = (res_o == 8'h00);
            stat_o[`BBSE_FLAG_N] = n;
            stat_o[`BBSE_FLAG_V] = n ^ c;
            stat_o[`BBSE_FLAG_S] = n ^ (n ^ c);
        end
    end
endmodule

// *** bbse_exec.v ***
// Execute stage for relative branches, I/O bit ops, shifts and flags.
// Assumes decode holds the op steady while BUSY_O is high and offers the
// next op only when BUSY_O is low; I/O data is read-modify-written.
// What this block does
// - Branch if overflow clear, 1/2 cycles
// - Branch if interrupt flag set, 1/2 cycles
// - Branch if interrupt flag clear, flags unchanged
// - Set I/O bit, others kept, 2 cycles
// - Clear I/O bit, others kept, 2 cycles
// - Logical shift left, update Z C N V
// - Logical shift right, update Z C N V
// - Rotate left through carry, update flags
// - Rotate right through carry, update flags
// - Arithmetic shift right keeps bit 7
// - Set or clear selected status bit
// - Copy register bit into transfer flag
`timescale 1ns/1ns
`include "bbse_defines.vh"
module bbse_exec (
    input wire CORE_CLK_I,        // Core clock, 125 MHz
    input wire RST_I,             // Synchronous reset, active high
    input wire OP_VALID_I,        // Op offered by decode
    input wire [3:0] OP_I,        // Operation code
    input wire [15:0] PC_I,       // Address of next instruction (PC+1 base)
    input wire [6:0] K_I,         // Signed branch offset k
    input wire [7:0] RD_I,        // Register operand value
    input wire [2:0] BIT_I,       // Bit select b or s
    input wire [4:0] IO_ADDR_I,   // I/O register address P
    input wire [7:0] IO_RDATA_I,  // I/O register read data
    output reg BUSY_O,            // Unit holds the current op
    output reg DONE_O,            // Op finished, one-cycle pulse
    output reg PC_LOAD_O,         // Branch taken, one-cycle pulse
    output reg [15:0] PC_O,       // Branch target
    output reg RD_WE_O,           // Register write, one-cycle pulse
    output reg [7:0] RD_O,        // Register result
    output reg IO_RE_O,           // I/O read strobe
    output reg IO_WE_O,           // I/O write strobe
    output reg [4:0] IO_ADDR_O,   // I/O address
    output reg [7:0] IO_WDATA_O,  // I/O write data
    output reg [7:0] STATUS_REGISTER_O       // Status register
);
    localparam ST_IDLE = 2'h0;
    localparam ST_BR2 = 2'h1;
    localparam ST_IO2 = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] status_register_q;
    reg [7:0] status_register_d;
    reg [15:0] tgt_q;
    reg [15:0] tgt_d;
    reg set_q;
    reg set_d;
    reg [2:0] bit_q;
    reg [2:0] bit_d;
    reg taken;
    wire [7:0] sh_res;
    wire [7:0] sh_status_register;

    function [7:0] onehot;
        input [2:0] b;
        begin
            onehot = 8'h01 << b;
        end
    endfunction

    bbse_shift u_shift (
        .op_i(OP_I),
        .rd_i(RD_I),
        .stat_i(status_register_q),
        .res_o(sh_res),
        .stat_o(sh_status_register)
    );

    always @* begin
        state_d = state_q;
        status_register_d = status_register_q;
        tgt_d = tgt_q;
        set_d = set_q;
        bit_d = bit_q;
        taken = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (OP_VALID_I) begin
                    case (OP_I)
                        `BBSE_OP_BR_VCLR:
                            taken = ~status_register_q[`BBSE_FLAG_V];
                        `BBSE_OP_BR_ISET:
                            taken = status_register_q[`BBSE_FLAG_I];
                        `BBSE_OP_BR_ICLR:
                            taken = ~status_register_q[`BBSE_FLAG_I];
                        `BBSE_OP_IOSET, `BBSE_OP_IOCLR: begin
                            state_d = ST_IO2;
                            set_d = (OP_I == `BBSE_OP_IOSET);
                            bit_d = BIT_I;
                        end
                        `BBSE_OP_SHL, `BBSE_OP_SHR, `BBSE_OP_RCL,
                        `BBSE_OP_RCR, `BBSE_OP_SAR, `BBSE_OP_SWAP:
                            status_register_d = sh_status_register;
                        `BBSE_OP_FSET:
                            status_register_d = status_register_q | onehot(BIT_I);
                        `BBSE_OP_FCLR:
                            status_register_d = status_register_q & ~onehot(BIT_I);
                        `BBSE_OP_BST:
                            status_register_d[`BBSE_FLAG_T] = RD_I[BIT_I];
                        default: begin
                            status_register_d = status_register_q;
                        end
                    endcase
                    if (taken) begin
                        state_d = ST_BR2;
                        tgt_d = PC_I + {{9{K_I[6]}}, K_I};
                    end
                end
            end
            ST_BR2: state_d = ST_IDLE;
            ST_IO2: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            status_register_q <= `BBSE_STAT_RST;
            tgt_q <= `BBSE_PC_RST;
            set_q <= 1'b0;
            bit_q <= 3'h0;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            PC_LOAD_O <= 1'b0;
            PC_O <= `BBSE_PC_RST;
            RD_WE_O <= 1'b0;
            RD_O <= 8'h00;
            IO_RE_O <= 1'b0;
            IO_WE_O <= 1'b0;
            IO_ADDR_O <= 5'h00;
            IO_WDATA_O <= 8'h00;
            STATUS_REGISTER_O <= `BBSE_STAT_RST;
        end else begin
            state_q <= state_d;
            status_register_q <= status_register_d;
            tgt_q <= tgt_d;
            set_q <= set_d;
            bit_q <= bit_d;
            STATUS_REGISTER_O <= status_register_d;
            BUSY_O <= (state_d != ST_IDLE);
            RD_WE_O <= 1'b0;
            PC_LOAD_O <= 1'b0;
            IO_WE_O <= 1'b0;
            IO_RE_O <= 1'b0;
            DONE_O <= 1'b0;
            if (state_q == ST_IDLE && OP_VALID_I) begin
                DONE_O <= (state_d == ST_IDLE);
                if (OP_I >= `BBSE_OP_SHL && OP_I <= `BBSE_OP_SWAP) begin
                    RD_WE_O <= 1'b1;
                    RD_O <= sh_res;
                end
                if (state_d == ST_IO2) begin
                    IO_RE_O <= 1'b1;
                    IO_ADDR_O <= IO_ADDR_I;
                end
            end
            if (state_q == ST_BR2) begin
                PC_LOAD_O <= 1'b1;
                PC_O <= tgt_q;
                DONE_O <= 1'b1;
            end
            if (state_q == ST_IO2) begin
                IO_WE_O <= 1'b1;
                DONE_O <= 1'b1;
                if (set_q)
                    IO_WDATA_O <= IO_RDATA_I | onehot(bit_q);
                else
                    IO_WDATA_O <= IO_RDATA_I & ~onehot(bit_q);
            end
        end
    end
endmodule

// *** bbse_exec_props.sv ***
// Port assertions for the exec unit.
// Assumes decode holds OP_I and operands steady while BUSY_O is high.
`timescale 1ns/1ns
module bbse_exec_props (
    input wire logic CORE_CLK_I, RST_I, OP_VALID_I, BUSY_O, DONE_O,
    input wire logic PC_LOAD_O, RD_WE_O, IO_RE_O, IO_WE_O,
    input wire logic [3:0] OP_I,
    input wire logic [15:0] PC_I, PC_O,
    input wire logic [6:0] K_I,
    input wire logic [7:0] RD_I, IO_RDATA_I, RD_O, IO_WDATA_O, STATUS_REGISTER_O,
    input wire logic [2:0] BIT_I
);
    wire acc = OP_VALID_I && !BUSY_O;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    a_branch_overflow_clear_taken: assert property (acc && OP_I == 4'h1 && !STATUS_REGISTER_O[3]
        |=> BUSY_O ##1 PC_LOAD_O && DONE_O && PC_O == $past(PC_I, 2)
        + {{9{$past(K_I[6], 2)}}, $past(K_I, 2)}) else $error("bad target");
    a_branch_overflow_clear_skip: assert property (acc && OP_I == 4'h1 && STATUS_REGISTER_O[3]
        |=> DONE_O && !BUSY_O && !PC_LOAD_O) else $error("bad skip");
    a_irq_off_br: assert property (acc && OP_I == 4'h3
        |=> BUSY_O != $past(STATUS_REGISTER_O[7]) && $stable(STATUS_REGISTER_O))
        else $error("bad branch on clear I");
    a_io_start: assert property (acc && OP_I[3:1] == 3'h2
        |=> IO_RE_O && BUSY_O && !DONE_O && $stable(STATUS_REGISTER_O))
        else $error("bad io start");
    a_io_write: assert property (IO_RE_O |=> IO_WE_O && DONE_O
        && IO_WDATA_O == ($past(OP_I) == 4'h4
        ? $past(IO_RDATA_I) | (8'h01 << $past(BIT_I))
        : $past(IO_RDATA_I) & ~(8'h01 << $past(BIT_I))))
        else $error("bad io write");
    a_lsl_result: assert property (acc && OP_I == 4'h6 |=> RD_WE_O
        && RD_O == {$past(RD_I[6:0]), 1'b0} && STATUS_REGISTER_O[0] == $past(RD_I[7]))
        else $error("bad shift left");
    a_swap_flags: assert property (acc && OP_I == 4'hb
        |=> RD_O == {$past(RD_I[3:0]), $past(RD_I[7:4])} && $stable(STATUS_REGISTER_O))
        else $error("bad swap");
    a_bst_copy: assert property (acc && OP_I == 4'he |=> STATUS_REGISTER_O ==
        {$past(STATUS_REGISTER_O[7]), $past(RD_I[BIT_I]), $past(STATUS_REGISTER_O[5:0])})
        else $error("bad bit store");
endmodule
bind bbse_exec bbse_exec_props u_props (.CORE_CLK_I, .RST_I, .OP_VALID_I,
    .BUSY_O, .DONE_O, .PC_LOAD_O, .RD_WE_O, .IO_RE_O, .IO_WE_O, .OP_I,
    .PC_I, .PC_O, .K_I, .RD_I, .IO_RDATA_I, .RD_O, .IO_WDATA_O, .STATUS_REGISTER_O,
    .BIT_I);

// *** bbse_io_model.sv ***
// I/O register space behind the exec unit, read combinationally.
// Assumes at most one write strobe per cycle.
`timescale 1ns/1ns
module bbse_io_model (
    input wire logic clk, re, we,    // Clock, read and write strobes
    input wire logic [4:0] addr,     // Register address
    input wire logic [7:0] wdata,    // Write data
    output logic [7:0] rdata         // Read data
);
    logic [7:0] mem [0:31];
    initial for (int i = 0; i < 32; i++) mem[i] = 8'h5a ^ i[7:0];
    // Inverted outside a read so stale data is caught
    assign rdata = re ? mem[addr] : ~mem[addr];
    always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule

// *** bbse_exec_tb.sv ***
// Self-checking bench for the exec unit with an I/O register model.
// Assumes a 125 MHz core clock and the opcode values of the hand-over.
`timescale 1ns/1ns
module bbse_exec_tb;
    logic clk = 0, rst = 1, vld = 0, busy, done, pcl, rwe, re, we;
    logic [3:0] op = 4'h0, so;
    logic [2:0] b = 3'h0;
    logic [4:0] ia;
    logic [7:0] rd = 8'h00, rdat, ro, wd, sro, sr = 8'h00, e, d;
    logic [15:0] pco;
    logic [8:0] r;
    int miscompares = 0, check_count = 0, cyc, i, j;
    always #4 clk = ~clk;
    bbse_exec dut (.CORE_CLK_I(clk), .RST_I(rst), .OP_VALID_I(vld),
        .OP_I(op), .PC_I(16'h0100), .K_I(7'h7e), .RD_I(rd), .BIT_I(b),
        .IO_ADDR_I(rd[4:0]), .IO_RDATA_I(rdat), .BUSY_O(busy),
        .DONE_O(done), .PC_LOAD_O(pcl), .PC_O(pco), .RD_WE_O(rwe),
        .RD_O(ro), .IO_RE_O(re), .IO_WE_O(we), .IO_ADDR_O(ia),
        .IO_WDATA_O(wd), .STATUS_REGISTER_O(sro));
    bbse_io_model io (.clk(clk), .re(re), .we(we), .addr(ia), .wdata(wd),
        .rdata(rdat));
    task test_done;
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] s, x);
        check_count++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    task run(input logic [3:0] o, input logic [7:0] dv,
        input logic [2:0] s, input int n);
        @(posedge clk);
        op <= o;
        rd <= dv;
        b <= s;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        cyc = 1;
        #1;
        while (done !== 1'b1 && cyc < 5) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (done !== 1'b1) begin
            miscompares++;
            test_done;
        end
        chk("cycles", cyc, n);
    endtask
    task br(input logic [3:0] o, input logic t);
        run(o, 8'h00, 3'h0, t ? 2 : 1);
        chk("pc_load", pcl, t);
        if (t)
            chk("pc", pco, 16'h00fe);
        chk("status_register", sro, sr);
    endtask
    task t_flags;
        for (i = 0; i < 16; i++) begin
            run(i < 8 ? 4'hc : 4'hd, 8'h00, i[2:0], 1);
            sr[i % 8] = i < 8;
            chk("status_register", sro, sr);
        end
        for (j = 0; j < 8; j++) begin
            run(4'he, 8'ha5, j[2:0], 1);
            sr[6] = 8'ha5 >> j;
            chk("status_register", sro, sr);
        end
        run(4'hf, 8'h00, 3'h0, 1);
        chk("status_register", sro, sr);
    endtask
    task t_branch;
        run(4'hd, 8'h00, 3'h3, 1);
        sr[3] = 0;
        br(4'h1, 1);
        run(4'hc, 8'h00, 3'h3, 1);
        sr[3] = 1;
        br(4'h1, 0);
        for (j = 0; j < 2; j++) begin
            run(j ? 4'hc : 4'hd, 8'h00, 3'h7, 1);
            sr[7] = j;
            br(4'h2, j);
            br(4'h3, !j);
        end
    endtask
    task t_io;
        for (j = 0; j < 4; j++) begin
            d = j < 2 ? 8'h03 : 8'h1f;
            i = j < 2 ? 2 : 7;
            run(j % 2 ? 4'h5 : 4'h4, d, i[2:0], 2);
            e = j % 2 ? e & ~(8'h01 << i) : (8'h5a ^ d) | (8'h01 << i);
            chk("io_we", we, 1'b1);
            chk("io_addr", ia, d[4:0]);
            chk("io_data", wd, e);
            chk("status_register", sro, sr);
        end
    endtask
    function automatic logic [8:0] shf(input logic [3:0] o,
        input logic [7:0] v, input logic c);
        case (o)
            4'h6: shf = {v, 1'b0};
            4'h7: shf = {v[0], 1'b0, v[7:1]};
            4'h8: shf = {v, c};
            4'h9: shf = {v[0], c, v[7:1]};
            4'ha: shf = {v[0], v[7], v[7:1]};
            default: shf = {c, v[3:0], v[7:4]};
        endcase
    endfunction
    task t_shift;
        for (j = 0; j < 12; j++) begin
            so = 4'h6 + j % 6;
            d = j < 6 ? 8'h81 : 8'h01;
            r = shf(so, d, sr[0]);
            run(so, d, 3'h0, 1);
            if (so != 4'hb)
                sr[4:0] = {r[8], r[7] ^ r[8], r[7], r[7:0] == 0, r[8]};
            chk("rd_we", rwe, 1'b1);
            chk("rd", ro, r[7:0]);
            chk("status_register", sro, sr);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        #1;
        chk("status_register", sro, 8'h00);
        t_flags;
        t_branch;
        t_io;
        t_shift;
        test_done;
    end
endmodule
